// [common/smc_pkg.sv]
// Behaviour
// - bit 7 selects saturating multiply-accumulate
// - bit 3 reports last reset source
// - bit 2 gates flash control register access
// - bit 0 enables on-chip RAM
// - RAM enable restored at reset release
// - mode 7 gives 16-Mbyte advanced space, ROM on
// - mode 7 starts single-chip until extended enabled
// - normal extended: ports 1, 2 inputs after reset
// - normal extended: address only where direction set
// - normal extended: port 3 data, 9/A control
// - normal extended: port 6 data when any area width clear
// - multiplexed 8-bit: port 2 address/data, port 1 general
// - multiplexed 16-bit: ports 1, 2 address/data
// - extended enable resets to zero, selects mode
package smc_pkg;
	localparam logic [11:0] SMC_OFF_SYSCTL  = 12'h000;
	localparam logic [11:0] SMC_OFF_MODECTL = 12'h004;
	localparam logic [11:0] SMC_OFF_BUSCFG  = 12'h008;
	localparam logic [11:0] SMC_OFF_PINROLE = 12'h00C;
	localparam int SMC_BIT_MAC_SATURATE_SELECT   = 7;
	localparam int SMC_BIT_RSRC   = 3;
	localparam int SMC_BIT_FLASH_CTRL_ACCESS_ENABLE = 2;
	localparam int SMC_BIT_ONCHIP_RAM_ENABLE   = 0;
	localparam int SMC_BIT_EXTENDED_MODE_ENABLE   = 7;
	localparam int SMC_BIT_MUX    = 4;
	localparam int SMC_BIT_BUS16  = 5;
	// writable sysctl bits: 7, 6..4, 2, 1, 0 (bit 3 is read-only)
	localparam logic [7:0] SMC_SYSCTL_WMASK = 8'hF7;
	localparam logic [7:0] SMC_SYSCTL_RST   = 8'h09;
	localparam logic [7:0] SMC_MODECTL_RST  = 8'h00;
	localparam logic [7:0] SMC_BUSCFG_RST   = 8'h0E;
	localparam logic [2:0] SMC_MODE7        = 3'h7;
	localparam logic [1:0] SMC_RESP_OKAY    = 2'h0;
	localparam logic [1:0] SMC_RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic       p1_addr_oe;
		logic       p2_addr_oe;
		logic       p1_muxad;
		logic       p2_muxad;
		logic       p3_data;
		logic       p6_data;
		logic       p9_ctrl;
		logic       pa_ctrl;
	} smc_pinrole_type;
endpackage

// [rtl/smc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_top
	import smc_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// reset cause: high when the last reset came from watchdog overflow
	input  wire logic        wdt_reset_cause,
	// mode pins
	input  wire logic [2:0]  mode_pins,
	// port direction bits for ports 1 and 2
	input  wire logic [7:0]  port1_ddr,
	input  wire logic [7:0]  port2_ddr,
	// axi4-lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// control outputs
	output logic             mac_saturate_select,
	output logic             flash_ctrl_access_enable,
	output logic             onchip_ram_enable,
	output logic             extended_mode_enable,
	output logic             advanced_mode,
	output logic             onchip_rom_enable,
	output smc_pinrole_type  pin_role,
	output logic [7:0]       port1_addr_oe,
	output logic [7:0]       port2_addr_oe
);
	logic [7:0]      system_control_register_r;
	logic [7:0]      mode_control_register_r;
	logic [7:0]      area_bus_control_register_r;
	logic [2:0]      mode_r;
	logic [2:0]      mode_s1_r;
	logic [2:0]      mode_s2_r;
	logic [2:0]      mode_s3_r;
	logic            rst_seen_r;
	logic            reset_source_flag_r;
	logic [11:0]     aw_addr_r;
	logic            aw_have_r;
	logic [31:0]     w_data_r;
	logic [3:0]      w_strb_r;
	logic            w_have_r;
	logic            wr_go;
	logic            mode7;
	logic            normal_ext;
	logic            mux_ext;
	smc_pinrole_type role_nxt;
	logic            wr_sysctl;
	logic            wr_modectl;
	logic            wr_buscfg;
	logic [31:0]     rd_word;
	logic [1:0]      rd_resp;

	function automatic logic [7:0] smc_merge(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [7:0] wmask);
		smc_merge = strb[0] ? ((old & ~wmask) | (d[7:0] & wmask)) : old;
	endfunction

	function automatic logic smc_known(input logic [11:0] a);
		smc_known = (a == SMC_OFF_SYSCTL) || (a == SMC_OFF_MODECTL)
			|| (a == SMC_OFF_BUSCFG) || (a == SMC_OFF_PINROLE);
	endfunction

	// a multiplexed bus overrides the direction bits; plain address drive follows them
	function automatic logic [7:0] smc_port_oe(input logic muxad, input logic addr_oe, input logic [7:0] ddr);
		smc_port_oe = muxad ? 8'hFF : (addr_oe ? ddr : 8'h00);
	endfunction

	// mode pins come from outside; only the second stage reads the first
	always_ff @(posedge clock)
	begin
		mode_s1_r <= mode_pins;
		mode_s2_r <= mode_s1_r;
		mode_s3_r <= mode_s2_r;
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			mode_r <= SMC_MODE7;
		else if (mode_s2_r == mode_s3_r)
			mode_r <= mode_s3_r;
	end

	// marks the first clock after release, the one capture point for the cause
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			rst_seen_r <= 1'b0;
		else
			rst_seen_r <= 1'b1;
	end

	// reset cause captured at release, never by the bus
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			reset_source_flag_r <= 1'b1;
		else if (!rst_seen_r)
			reset_source_flag_r <= ~wdt_reset_cause;
	end

	// write channels taken in either order, response after both
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
	assign wr_go         = aw_have_r && w_have_r;
	// one strobe per register keeps the address compare out of each register block
	assign wr_sysctl     = wr_go && (aw_addr_r == SMC_OFF_SYSCTL);
	assign wr_modectl    = wr_go && (aw_addr_r == SMC_OFF_MODECTL);
	assign wr_buscfg     = wr_go && (aw_addr_r == SMC_OFF_BUSCFG);

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_have_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			else if (wr_go)
				w_have_r <= 1'b0;
		end
	end

	// write answer stands until the master takes it
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= SMC_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= smc_known(aw_addr_r) ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// reserved bits are stored as written; keeping them zero is software's job
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			system_control_register_r <= SMC_SYSCTL_RST;
		else if (wr_sysctl)
			system_control_register_r <= smc_merge(system_control_register_r, w_data_r, w_strb_r,
				SMC_SYSCTL_WMASK);
	end

	// only the enable bit is writable; mode-select field mirrors the pins
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			mode_control_register_r <= SMC_MODECTL_RST;
		else if (wr_modectl)
			mode_control_register_r <= smc_merge(mode_control_register_r, w_data_r, w_strb_r,
				8'h80);
	end

	// bits 3..1 are area 1..3 bus width, bit 4 multiplex, bit 5 16-bit multiplexed bus
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			area_bus_control_register_r <= SMC_BUSCFG_RST;
		else if (wr_buscfg)
			area_bus_control_register_r <= smc_merge(area_bus_control_register_r, w_data_r,
				w_strb_r, 8'h3E);
	end

	// read channel: one-cycle answer, held until taken
	assign s_axi_arready = !s_axi_rvalid;

	// read word decode; upper bytes read as zero
	always_comb
	begin
		rd_resp = smc_known(s_axi_araddr) ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
		case (s_axi_araddr)
			SMC_OFF_SYSCTL:
				rd_word = {24'h000000, system_control_register_r[7:4], reset_source_flag_r,
					system_control_register_r[2:0]};
			SMC_OFF_MODECTL:
				rd_word = {24'h000000, mode_control_register_r[SMC_BIT_EXTENDED_MODE_ENABLE], 4'h0, mode_r};
			SMC_OFF_BUSCFG:
				rd_word = {24'h000000, area_bus_control_register_r};
			SMC_OFF_PINROLE:
				rd_word = {24'h000000, pin_role};
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= SMC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= rd_resp;
			s_axi_rdata  <= rd_word;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// pin role decode
	assign mode7      = (mode_r == SMC_MODE7);
	assign normal_ext = mode7 && mode_control_register_r[SMC_BIT_EXTENDED_MODE_ENABLE]
		&& !area_bus_control_register_r[SMC_BIT_MUX];
	assign mux_ext    = mode7 && mode_control_register_r[SMC_BIT_EXTENDED_MODE_ENABLE]
		&& area_bus_control_register_r[SMC_BIT_MUX];

	always_comb
	begin
		role_nxt            = '0;
		role_nxt.p1_addr_oe = normal_ext;
		role_nxt.p2_addr_oe = normal_ext;
		role_nxt.p3_data    = normal_ext;
		role_nxt.p9_ctrl    = normal_ext || mux_ext;
		role_nxt.pa_ctrl    = normal_ext || mux_ext;
		role_nxt.p6_data    = normal_ext && (area_bus_control_register_r[3:1] != 3'h7);
		role_nxt.p2_muxad   = mux_ext;
		role_nxt.p1_muxad   = mux_ext && area_bus_control_register_r[SMC_BIT_BUS16];
	end

	// pin roles registered; reset leaves ports 1, 2 as plain inputs
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			pin_role <= '0;
		else
			pin_role <= role_nxt;
	end

	// port 1 drives address where its direction bit is set, or all of it on a 16-bit muxed bus
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			port1_addr_oe <= 8'h00;
		else
			port1_addr_oe <= smc_port_oe(role_nxt.p1_muxad, role_nxt.p1_addr_oe, port1_ddr);
	end

	// port 2 likewise; any muxed bus claims all of it
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			port2_addr_oe <= 8'h00;
		else
			port2_addr_oe <= smc_port_oe(role_nxt.p2_muxad, role_nxt.p2_addr_oe, port2_ddr);
	end

	assign mac_saturate_select      = system_control_register_r[SMC_BIT_MAC_SATURATE_SELECT];
	assign flash_ctrl_access_enable = system_control_register_r[SMC_BIT_FLASH_CTRL_ACCESS_ENABLE];
	assign onchip_ram_enable        = system_control_register_r[SMC_BIT_ONCHIP_RAM_ENABLE];
	assign extended_mode_enable     = mode_control_register_r[SMC_BIT_EXTENDED_MODE_ENABLE];
	assign advanced_mode            = mode7;
	assign onchip_rom_enable        = mode7;
endmodule
`default_nettype wire

// [tb/smc_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_top_sva
	import smc_pkg::*;
(
	// clock and reset
	input wire logic            clock,
	input wire logic            reset_n,
	// watched inputs
	input wire logic [2:0]      mode_pins,
	input wire logic [7:0]      port1_ddr,
	input wire logic [7:0]      port2_ddr,
	// watched outputs
	input wire logic            mac_saturate_select,
	input wire logic            flash_ctrl_access_enable,
	input wire logic            onchip_ram_enable,
	input wire logic            extended_mode_enable,
	input wire logic            advanced_mode,
	input wire logic            onchip_rom_enable,
	input wire smc_pinrole_type pin_role,
	input wire logic [7:0]      port1_addr_oe,
	input wire logic [7:0]      port2_addr_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_ram_init;
		$rose(reset_n) |-> onchip_ram_enable;
	endproperty
	a_ram_init: assert property (p_ram_init) else $error("ram enable low after reset");
	property p_clr_init;
		$rose(reset_n) |-> !mac_saturate_select && !flash_ctrl_access_enable && !extended_mode_enable;
	endproperty
	a_clr_init: assert property (p_clr_init) else $error("control bit set after reset");
	property p_rom;
		$past(mode_pins, 4) == SMC_MODE7 && $past(mode_pins, 3) == SMC_MODE7 |-> advanced_mode && onchip_rom_enable;
	endproperty
	a_rom: assert property (p_rom) else $error("rom off in mode 7");
	property p_single;
		pin_role.p3_data || pin_role.p2_muxad |-> $past(extended_mode_enable && advanced_mode);
	endproperty
	a_single: assert property (p_single) else $error("bus pins without extended mode");
	property p_oe_ddr;
		(pin_role.p1_muxad || (port1_addr_oe & ~$past(port1_ddr)) == 8'h00)
			&& (pin_role.p2_muxad || (port2_addr_oe & ~$past(port2_ddr)) == 8'h00);
	endproperty
	a_oe_ddr: assert property (p_oe_ddr) else $error("address drive without direction");
	property p_mux8;
		pin_role.p2_muxad |-> port2_addr_oe == 8'hFF && !pin_role.p3_data;
	endproperty
	a_mux8: assert property (p_mux8) else $error("port 2 not multiplexed");
	property p_mux16;
		pin_role.p1_muxad |-> pin_role.p2_muxad && port1_addr_oe == 8'hFF;
	endproperty
	a_mux16: assert property (p_mux16) else $error("port 1 not multiplexed");
	property p_normal;
		pin_role.p3_data |-> pin_role.p9_ctrl && pin_role.pa_ctrl;
	endproperty
	a_normal: assert property (p_normal) else $error("control pins missing");
	property p_p6;
		pin_role.p6_data |-> pin_role.p3_data;
	endproperty
	a_p6: assert property (p_p6) else $error("port 6 data outside normal mode");
	property p_inputs;
		$rose(reset_n) |-> port1_addr_oe == 8'h00 && port2_addr_oe == 8'h00;
	endproperty
	a_inputs: assert property (p_inputs) else $error("ports drive after reset");
endmodule

bind smc_top smc_top_sva u_chk (.*);
`default_nettype wire

// [tb/tb_system_control_mode_config.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_system_control_mode_config;
	import smc_pkg::*;
	logic            clock, reset_n, wdt_reset_cause;
	logic [2:0]      mode_pins;
	logic [7:0]      port1_ddr, port2_ddr, port1_addr_oe, port2_addr_oe;
	logic [11:0]     s_axi_awaddr, s_axi_araddr;
	logic [31:0]     s_axi_wdata, s_axi_rdata;
	logic [3:0]      s_axi_wstrb;
	logic [1:0]      s_axi_bresp, s_axi_rresp;
	logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic            mac_saturate_select, flash_ctrl_access_enable, onchip_ram_enable, extended_mode_enable;
	logic            advanced_mode, onchip_rom_enable;
	smc_pinrole_type pin_role;
	int              bad_count, tests_run;

	smc_top dut (.*);

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic conclude;
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		tests_run++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask

	// bready held from the start; the answer is taken at the edge bvalid is seen
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end
		while (s_axi_bvalid !== 1'b1 && n < 40);
		s_axi_bready <= 1'b0;
		chk(n < 40, 1'b1, "write wait");
		if (n >= 40) conclude();
		chk(s_axi_bresp, SMC_RESP_OKAY, "bresp");
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end
		while (s_axi_rvalid !== 1'b1 && n < 40);
		s_axi_rready <= 1'b0;
		chk(n < 40, 1'b1, "read wait");
		if (n >= 40) conclude();
		chk(s_axi_rdata, e, "rdata");
		chk(s_axi_rresp, er, "rresp");
	endtask

	task automatic rst(input logic cause);
		@(posedge clock);
		reset_n <= 1'b0;
		wdt_reset_cause <= cause;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	initial
	begin
		{reset_n, wdt_reset_cause, port1_ddr, port2_ddr, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{bad_count, tests_run} = '0;
		mode_pins = SMC_MODE7;
		s_axi_wstrb = 4'hF;
		rst(1'b0);
		rd(SMC_OFF_SYSCTL, 32'h09, SMC_RESP_OKAY);
		chk({mac_saturate_select, flash_ctrl_access_enable, onchip_ram_enable}, 3'b001, "ctl");
		rd(SMC_OFF_MODECTL, 32'h07, SMC_RESP_OKAY);
		wr(SMC_OFF_SYSCTL, 32'h84);
		rd(SMC_OFF_SYSCTL, 32'h8C, SMC_RESP_OKAY);
		chk({mac_saturate_select, flash_ctrl_access_enable, onchip_ram_enable}, 3'b110, "ctl");
		rst(1'b1);
		rd(SMC_OFF_SYSCTL, 32'h01, SMC_RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(SMC_OFF_SYSCTL, 32'h80);
		rd(SMC_OFF_SYSCTL, 32'h01, SMC_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		chk(pin_role, 8'h00, "roles");
		wr(SMC_OFF_MODECTL, 32'h80);
		repeat (3) @(posedge clock);
		chk({port1_addr_oe, port2_addr_oe}, 16'h0000, "oe");
		chk({pin_role.p3_data, pin_role.p6_data, pin_role.p9_ctrl, pin_role.pa_ctrl}, 4'hB, "roles");
		chk({extended_mode_enable, advanced_mode, onchip_rom_enable}, 3'b111, "ext");
		rd(SMC_OFF_MODECTL, 32'h87, SMC_RESP_OKAY);
		port1_ddr <= 8'h0F;
		port2_ddr <= 8'hF0;
		wr(SMC_OFF_BUSCFG, 32'h0C);
		repeat (3) @(posedge clock);
		chk({port1_addr_oe, port2_addr_oe}, 16'h0FF0, "oe");
		chk(pin_role.p6_data, 1'b1, "p6");
		wr(SMC_OFF_BUSCFG, 32'h1E);
		repeat (3) @(posedge clock);
		chk({pin_role.p1_muxad, pin_role.p2_muxad, pin_role.p3_data}, 3'b010, "mux8");
		chk({port1_addr_oe, port2_addr_oe}, 16'h00FF, "oe");
		wr(SMC_OFF_BUSCFG, 32'h3E);
		repeat (3) @(posedge clock);
		chk({pin_role.p1_muxad, pin_role.p2_muxad, port1_addr_oe}, 10'h3FF, "mux16");
		rd(12'h010, 32'h0, SMC_RESP_SLVERR);
		mode_pins <= 3'h5;
		repeat (8) @(posedge clock);
		chk({advanced_mode, onchip_rom_enable, pin_role}, 10'h000, "mode");
		conclude();
	end
endmodule
`default_nettype wire
